// file: mcic_pkg.sv
// Function
// RULE1: start bit runs scanning, zero means standby
// RULE2: clearing start leaves interrupt output asserted
// RULE3: host programs all limits before setting start
// RULE4: configuration resets to 08h
// RULE5: interrupt enable bit gates interrupt output
// RULE6: interrupt clear forces output off, keeps status
// RULE7: interrupt clear suspends monitoring until cleared
// RULE8: reset bit drives reset low 20 ms
// RULE9: reset bit clears once pulse starts
// RULE10: chassis bit pulses chassis pin low 20 ms
// RULE11: init bit restores defaults, reads zero
// RULE12: voltage flags set on limit crossing
// RULE13: temperature flag sets on temperature event
// RULE14: fan flags set on fan count limit
// RULE15: chassis flag sets when intrusion goes high
// RULE16: reading status clears returned flags
// RULE17: remaining condition raises a fresh indication
// RULE18: primary mask bits block primary flags
// RULE19: secondary mask blocks 12V, core two, chassis
// RULE20: reset pulse acts only with enable bit
// RULE21: interrupt asserts on unmasked flag when enabled
// RULE22: reserved status reads zero, reserved bits stored
package mcic_pkg;
  // ****************************************************
  // register addresses
  // ****************************************************
  localparam logic [7:0] ADDR_CFG = 8'h40;
  localparam logic [7:0] ADDR_STAT1 = 8'h41;
  localparam logic [7:0] ADDR_STAT2 = 8'h42;
  localparam logic [7:0] ADDR_MASK1 = 8'h43;
  localparam logic [7:0] ADDR_MASK2 = 8'h44;
  localparam logic [7:0] ADDR_CI_CLEAR = 8'h46;
  localparam logic [7:0] ADDR_FAN_DIV = 8'h47;
  localparam logic [7:0] ADDR_TEMP_CFG = 8'h4B;
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int CFG_START = 0;
  localparam int CFG_INT_EN = 1;
  localparam int CFG_INT_CLR = 3;
  localparam int CFG_RST_PULSE = 4;
  localparam int CFG_CI_PULSE = 6;
  localparam int CFG_INIT = 7;
  localparam int MASK2_RST_EN = 7;
  localparam int CI_CLEAR_BIT = 7;
  localparam int ST1_RAIL25 = 0;
  localparam int ST1_CORE1 = 1;
  localparam int ST1_RAIL33 = 2;
  localparam int ST1_RAIL5 = 3;
  localparam int ST1_TEMP = 4;
  localparam int ST1_FAN1 = 6;
  localparam int ST1_FAN2 = 7;
  localparam int ST2_RAIL12 = 0;
  localparam int ST2_CORE2 = 1;
  localparam int ST2_CHASSIS = 4;
  // ****************************************************
  // reset values and implemented bits
  // ****************************************************
  localparam logic [7:0] CFG_RST = 8'h08;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [3:0] FAN_DIV_RST = 4'h5;
  localparam logic [7:0] TEMP_CFG_RST = 8'h01;
  localparam logic [7:0] STAT1_VALID = 8'hDF;
  localparam logic [7:0] STAT2_VALID = 8'h13;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int PULSE_MS = 20;
  localparam int CLK_KHZ = 250000;
  localparam int PULSE_CYCLES_DEF = PULSE_MS * CLK_KHZ;
endpackage

// file: mcic_pulse_if.sv
`timescale 1ns/1ps
interface mcic_pulse_if;
  logic start;
  logic done;
  logic pin_n;
  modport ctl (output start, input done, input pin_n);
  modport gen (input start, output done, output pin_n);
endinterface

// file: mcic_sync.sv
`timescale 1ns/1ps
module mcic_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  import mcic_pkg::*;
  logic [W-1:0] meta;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// file: mcic_pulse_gen.sv
`timescale 1ns/1ps
module mcic_pulse_gen #(
  parameter int unsigned CYCLES = mcic_pkg::PULSE_CYCLES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  mcic_pulse_if.gen pulse
);
  import mcic_pkg::*;
  logic [31:0] count;
  // last low cycle; the chassis pulse owner clears its requests on this, the reset owner clears at pulse start
  assign pulse.done = !pulse.pin_n && (count == 32'h0000_0000);
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pulse.pin_n <= 1'b1;
      count <= 32'h0000_0000;
    end
    else if (pulse.pin_n && pulse.start)
    begin
      pulse.pin_n <= 1'b0;
      count <= 32'(CYCLES - 1);
    end
    else if (!pulse.pin_n)
    begin
      if (count == 32'h0000_0000)
        pulse.pin_n <= 1'b1;
      else
        count <= count - 32'h0000_0001;
    end
  end
endmodule

// file: mcic_top.sv
`timescale 1ns/1ps
module mcic_top #(
  parameter int unsigned PULSE_CYCLES = mcic_pkg::PULSE_CYCLES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_rail_25_fault,
  input wire logic i_core_rail_one_fault,
  input wire logic i_rail_33_fault,
  input wire logic i_rail_5_fault,
  input wire logic i_rail_12_fault,
  input wire logic i_core_rail_two_fault,
  input wire logic i_temp_fault,
  input wire logic i_fan_one_fault,
  input wire logic i_fan_two_fault,
  input wire logic i_chassis_pin,
  output logic o_chassis_pin,
  output logic o_chassis_pin_oe_n,
  input wire logic [3:0] i_vid,
  output logic o_reset_n,
  output logic o_int_n,
  output logic o_scan_enable,
  output logic [3:0] o_fan_divisor,
  output logic [1:0] o_temp_mode
);
  import mcic_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  logic [7:0] cfg;
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic [7:0] mask1;
  logic [7:0] mask2;
  logic ci_clear;
  logic [3:0] fan_div;
  logic [7:0] temp_cfg;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic ci_sync;
  logic ci_prev;
  logic ci_rise;
  logic [3:0] vid_sync;
  logic wr_cfg;
  logic init_wr;
  logic rd_stat1;
  logic rd_stat2;
  logic monitor;
  logic pending;

  mcic_pulse_if rst_pulse ();
  mcic_pulse_if ci_pulse ();

  function automatic logic [7:0] mcic_flag_next(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic [7:0] clr
  );
    // a set in the clearing cycle survives
    return (cur & ~clr) | set;
  endfunction

  // ****************************************************
  // pin synchronisers and pulse generators
  // ****************************************************
  mcic_sync #(
    .W(1)
  ) u_ci_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_chassis_pin),
    .o_sync(ci_sync)
  );

  mcic_sync #(
    .W(4)
  ) u_vid_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_vid),
    .o_sync(vid_sync)
  );

  mcic_pulse_gen #(
    .CYCLES(PULSE_CYCLES)
  ) u_rst_gen (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .pulse(rst_pulse.gen)
  );

  mcic_pulse_gen #(
    .CYCLES(PULSE_CYCLES)
  ) u_ci_gen (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .pulse(ci_pulse.gen)
  );

  // ****************************************************
  // decode
  // ****************************************************
  assign wr_cfg = i_reg_wr && (i_reg_addr == ADDR_CFG);
  assign init_wr = wr_cfg && i_reg_wdata[CFG_INIT]; // see RULE11
  assign rd_stat1 = i_reg_rd && (i_reg_addr == ADDR_STAT1);
  assign rd_stat2 = i_reg_rd && (i_reg_addr == ADDR_STAT2);
  // monitoring halts in standby and while the clear bit is held
  assign monitor = cfg[CFG_START] && !cfg[CFG_INT_CLR]; // see RULE1 RULE7
  assign o_scan_enable = monitor;
  assign ci_rise = ci_sync && !ci_prev;

  // reset pulse needs the enable in the secondary mask
  assign rst_pulse.start = cfg[CFG_RST_PULSE] && mask2[MASK2_RST_EN]; // see RULE20
  assign ci_pulse.start = cfg[CFG_CI_PULSE] || ci_clear; // see RULE10
  assign o_reset_n = rst_pulse.pin_n; // see RULE8
  assign o_chassis_pin = 1'b0;
  assign o_chassis_pin_oe_n = ci_pulse.pin_n;
  assign o_fan_divisor = fan_div;
  assign o_temp_mode = temp_cfg[1:0];

  // ****************************************************
  // configuration register
  // ****************************************************
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      cfg <= CFG_RST; // see RULE4
    else if (init_wr)
      cfg <= CFG_RST; // see RULE11
    else if (wr_cfg)
    begin
      // reserved bits are kept, init bit is never stored
      cfg <= i_reg_wdata & ~(8'h01 << CFG_INIT); // see RULE22
      cfg[CFG_RST_PULSE] <= i_reg_wdata[CFG_RST_PULSE]
                            && mask2[MASK2_RST_EN]; // see RULE20
    end
    else
    begin
      if (rst_pulse.start && rst_pulse.pin_n)
        cfg[CFG_RST_PULSE] <= 1'b0; // see RULE9
      if (ci_pulse.done)
        cfg[CFG_CI_PULSE] <= 1'b0;
    end
  end

  // ****************************************************
  // mask, divisor and auxiliary registers
  // ****************************************************
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mask1 <= MASK_RST; // see RULE18
      mask2 <= MASK_RST;
      fan_div <= FAN_DIV_RST;
      temp_cfg <= TEMP_CFG_RST;
    end
    else if (init_wr)
    begin
      mask1 <= MASK_RST; // see RULE11
      mask2 <= MASK_RST;
      fan_div <= FAN_DIV_RST;
      temp_cfg <= TEMP_CFG_RST;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == ADDR_MASK1)
        mask1 <= i_reg_wdata;
      else if (i_reg_addr == ADDR_MASK2)
        mask2 <= i_reg_wdata; // see RULE19
      else if (i_reg_addr == ADDR_FAN_DIV)
        fan_div <= i_reg_wdata[7:4];
      else if (i_reg_addr == ADDR_TEMP_CFG)
        temp_cfg <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ci_clear <= 1'b0;
    else if (i_reg_wr && (i_reg_addr == ADDR_CI_CLEAR))
      ci_clear <= i_reg_wdata[CI_CLEAR_BIT];
    else if (ci_pulse.done)
      ci_clear <= 1'b0;
  end

  // ****************************************************
  // status flags
  // ****************************************************
  always_comb
  begin
    set1 = STAT_RST;
    set2 = STAT_RST;
    set1[ST1_RAIL25] = i_rail_25_fault; // see RULE12
    set1[ST1_CORE1] = i_core_rail_one_fault;
    set1[ST1_RAIL33] = i_rail_33_fault;
    set1[ST1_RAIL5] = i_rail_5_fault;
    set1[ST1_TEMP] = i_temp_fault; // see RULE13
    set1[ST1_FAN1] = i_fan_one_fault; // see RULE14
    set1[ST1_FAN2] = i_fan_two_fault;
    set2[ST2_RAIL12] = i_rail_12_fault;
    set2[ST2_CORE2] = i_core_rail_two_fault;
    set2[ST2_CHASSIS] = ci_rise && !cfg[CFG_INT_CLR]; // see RULE15 RULE6
    if (!monitor)
    begin
      set1 = STAT_RST;
      set2[ST2_RAIL12] = 1'b0;
      set2[ST2_CORE2] = 1'b0;
    end
    clr1 = (rd_stat1 || init_wr) ? ALL_ONES : STAT_RST; // see RULE16
    clr2 = (rd_stat2 || init_wr) ? ALL_ONES : STAT_RST;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ci_prev <= 1'b0;
    else
      ci_prev <= ci_sync;
  end

  // a condition still present after a read sets its flag again
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      stat1 <= STAT_RST;
      stat2 <= STAT_RST;
    end
    else
    begin
      stat1 <= mcic_flag_next(stat1, set1, clr1)
               & STAT1_VALID; // see RULE17 RULE22
      stat2 <= mcic_flag_next(stat2, set2, clr2) & STAT2_VALID;
    end
  end

  // ****************************************************
  // interrupt output
  // ****************************************************
  assign pending = |(stat1 & ~mask1) || |(stat2 & ~mask2 & STAT2_VALID);

  // start is not looked at, so standby keeps the pin asserted
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_int_n <= 1'b1;
    else
      o_int_n <= !(cfg[CFG_INT_EN] && !cfg[CFG_INT_CLR]
                   && pending); // see RULE21 RULE5 RULE2
  end

  // ****************************************************
  // read data
  // ****************************************************
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      if (i_reg_addr == ADDR_CFG)
        o_reg_rdata <= cfg;
      else if (i_reg_addr == ADDR_STAT1)
        o_reg_rdata <= stat1;
      else if (i_reg_addr == ADDR_STAT2)
        o_reg_rdata <= stat2;
      else if (i_reg_addr == ADDR_MASK1)
        o_reg_rdata <= mask1;
      else if (i_reg_addr == ADDR_MASK2)
        o_reg_rdata <= mask2;
      else if (i_reg_addr == ADDR_CI_CLEAR)
        o_reg_rdata <= {ci_clear, 7'h00};
      else if (i_reg_addr == ADDR_FAN_DIV)
        o_reg_rdata <= {fan_div, vid_sync};
      else if (i_reg_addr == ADDR_TEMP_CFG)
        o_reg_rdata <= temp_cfg;
      else
        o_reg_rdata <= 8'h00;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  logic [31:0] rst_low_cnt;
  logic [31:0] ci_low_cnt;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rst_low_cnt <= 32'h0000_0000;
      ci_low_cnt <= 32'h0000_0000;
    end
    else
    begin
      rst_low_cnt <= o_reset_n ? 32'h0000_0000 : rst_low_cnt + 32'h0000_0001;
      ci_low_cnt <= o_chassis_pin_oe_n ? 32'h0000_0000
                                       : ci_low_cnt + 32'h0000_0001;
    end
  end

  property p_int_gate;
    @(posedge i_clk) disable iff (i_rst)
    (!cfg[CFG_INT_EN] || cfg[CFG_INT_CLR]) |=> o_int_n;
  endproperty
  a_int_gate: assert property (p_int_gate) // see RULE5 RULE6
    else $error("interrupt asserted while gated");

  property p_int_assert;
    @(posedge i_clk) disable iff (i_rst)
    (cfg[CFG_INT_EN] && !cfg[CFG_INT_CLR] && pending) |=> !o_int_n;
  endproperty
  a_int_assert: assert property (p_int_assert) // see RULE21
    else $error("interrupt missing for pending flag");

  property p_start_keeps_int;
    @(posedge i_clk) disable iff (i_rst)
    (!o_int_n && $fell(cfg[CFG_START]) && cfg[CFG_INT_EN]
     && !cfg[CFG_INT_CLR] && pending) |=> !o_int_n;
  endproperty
  a_start_keeps_int: assert property (p_start_keeps_int) // see RULE2
    else $error("clearing start removed the interrupt");

  property p_masked;
    @(posedge i_clk) disable iff (i_rst)
    ((stat1 & ~mask1) == 8'h00 && (stat2 & ~mask2) == 8'h00) |=> o_int_n;
  endproperty
  a_masked: assert property (p_masked) // see RULE18 RULE19
    else $error("masked flag reached interrupt");

  property p_no_scan_set;
    @(posedge i_clk) disable iff (i_rst)
    !monitor |=> (stat1 & ~$past(stat1)) == 8'h00;
  endproperty
  a_no_scan_set: assert property (p_no_scan_set) // see RULE1 RULE7
    else $error("primary flag set while not monitoring");

  property p_rst_len;
    @(posedge i_clk) disable iff (i_rst)
    $rose(o_reset_n) |-> rst_low_cnt == 32'(PULSE_CYCLES);
  endproperty
  a_rst_len: assert property (p_rst_len) // see RULE8
    else $error("reset pulse length wrong");

  property p_ci_len;
    @(posedge i_clk) disable iff (i_rst)
    $rose(o_chassis_pin_oe_n) |-> ci_low_cnt == 32'(PULSE_CYCLES);
  endproperty
  a_ci_len: assert property (p_ci_len) // see RULE10
    else $error("chassis pulse length wrong");

  property p_rst_selfclear;
    @(posedge i_clk) disable iff (i_rst)
    $fell(o_reset_n) |-> !cfg[CFG_RST_PULSE];
  endproperty
  a_rst_selfclear: assert property (p_rst_selfclear) // see RULE9
    else $error("reset bit not cleared at pulse start");

  property p_rst_enable;
    @(posedge i_clk) disable iff (i_rst)
    (o_reset_n && !mask2[MASK2_RST_EN]) |=> o_reset_n;
  endproperty
  a_rst_enable: assert property (p_rst_enable) // see RULE20
    else $error("reset pulse without enable");

  property p_init;
    @(posedge i_clk) disable iff (i_rst)
    init_wr |=> (cfg == CFG_RST && mask1 == MASK_RST && mask2 == MASK_RST
                 && fan_div == FAN_DIV_RST && temp_cfg == TEMP_CFG_RST);
  endproperty
  a_init: assert property (p_init) // see RULE11
    else $error("init did not restore defaults");

  property p_rd_clear;
    @(posedge i_clk) disable iff (i_rst)
    rd_stat1 |=> stat1 == ($past(set1) & STAT1_VALID);
  endproperty
  a_rd_clear: assert property (p_rd_clear) // see RULE16 RULE17
    else $error("status read did not clear");

  property p_chassis;
    @(posedge i_clk) disable iff (i_rst)
    (ci_rise && !cfg[CFG_INT_CLR]) |=> stat2[ST2_CHASSIS];
  endproperty
  a_chassis: assert property (p_chassis) // see RULE15
    else $error("chassis flag not set");

  property p_reserved;
    @(posedge i_clk) disable iff (i_rst)
    (stat1 & ~STAT1_VALID) == 8'h00 && (stat2 & ~STAT2_VALID) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) // see RULE22
    else $error("reserved status bit set");

  c_int: cover property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_int_n));
  c_rst_pulse: cover property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_reset_n));
  c_ci_pulse: cover property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_chassis_pin_oe_n));
  c_refresh: cover property (@(posedge i_clk) disable iff (i_rst)
    rd_stat1 ##1 (stat1 != 8'h00));
endmodule

// file: mcic_host_model.sv
`timescale 1ns/1ps
module mcic_host_model (
  input wire logic i_clk,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  initial
  begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // released lines show the inverse, so a stale value never passes
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    d = i_reg_rdata;
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mcic_pkg::*;
  localparam int unsigned PC = 8;
  logic clk, rst, wr, rd, scan, rst_n, int_n, ci_out, ci_oe_n, ci_wire;
  logic [7:0] addr, wdata, rdata, f1, f2, d;
  logic [3:0] vid, fdiv;
  logic [1:0] tmode;
  int n_mismatch, checks_done, n;
  logic [7:0] ta [6];
  logic [7:0] te [6];

  // open-drain pin: our pulse pulls low, otherwise the intrusion source rules
  assign ci_wire = ci_oe_n ? f2[4] : ci_out;

  mcic_host_model host (.i_clk(clk), .o_reg_addr(addr), .o_reg_wr(wr),
    .o_reg_rd(rd), .o_reg_wdata(wdata), .i_reg_rdata(rdata));

  mcic_top #(.PULSE_CYCLES(PC)) dut (.i_clk(clk), .i_rst(rst),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_rail_25_fault(f1[0]),
    .i_core_rail_one_fault(f1[1]), .i_rail_33_fault(f1[2]),
    .i_rail_5_fault(f1[3]), .i_rail_12_fault(f2[0]),
    .i_core_rail_two_fault(f2[1]), .i_temp_fault(f1[4]),
    .i_fan_one_fault(f1[6]), .i_fan_two_fault(f1[7]),
    .i_chassis_pin(ci_wire), .o_chassis_pin(ci_out),
    .o_chassis_pin_oe_n(ci_oe_n), .i_vid(vid), .o_reset_n(rst_n),
    .o_int_n(int_n), .o_scan_enable(scan), .o_fan_divisor(fdiv),
    .o_temp_mode(tmode));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                      input string m);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    chk8({7'h00, g}, {7'h00, e}, m);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    f1 <= a;
    f2 <= b;
    @(posedge clk);
    f1 <= 8'h00;
    f2 <= 8'h00;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.read_reg(a, d);
    chk8(d, e, "register read");
  endtask

  // sel 1 watches the chassis pin enable, sel 0 the reset output
  task automatic count_low(input bit sel, output int k);
    int w;
    w = 0;
    k = 0;
    while ((sel ? ci_oe_n : rst_n) !== 1'b0 && w < 20)
    begin
      cyc(1);
      w++;
    end
    if (w == 20)
    begin
      n_mismatch++;
      $display("BAD t=%0t pulse never started", $time);
      print_verdict();
    end
    while ((sel ? ci_oe_n : rst_n) === 1'b0 && k < 100)
    begin
      if (sel)
        chk1(ci_wire, 1'b0, "chassis pin driven");
      cyc(1);
      k++;
    end
    if (k == 100)
    begin
      n_mismatch++;
      $display("BAD t=%0t pulse never ended", $time);
      print_verdict();
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial
  begin
    rst = 1'b1;
    f1 = 8'h00;
    f2 = 8'h00;
    vid = 4'hA;
    n_mismatch = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_CFG, CFG_RST);
    rd_chk(ADDR_STAT1, 8'h00);
    rd_chk(ADDR_MASK1, 8'h00);
    chk1(scan, 1'b0, "scan after reset");
    $display("test reset done");

    // limits live outside this block; the primary mask is set before start
    host.write_reg(ADDR_MASK1, 8'h00);
    host.write_reg(ADDR_CFG, 8'h27);
    rd_chk(ADDR_CFG, 8'h27);
    chk1(scan, 1'b1, "scan on");
    host.write_reg(ADDR_CFG, 8'h03);
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i, 8'h01 << i);
      cyc(6);
      // bit 5 is reserved in both status registers, so no interrupt then
      n = ((8'h01 << i) & (STAT1_VALID | STAT2_VALID)) == 8'h00;
      chk1(int_n, n[0], "int on flag");
      rd_chk(ADDR_STAT1, (8'h01 << i) & STAT1_VALID);
      rd_chk(ADDR_STAT1, 8'h00);
      rd_chk(ADDR_STAT2, (8'h01 << i) & STAT2_VALID);
      rd_chk(ADDR_STAT2, 8'h00);
      cyc(2);
      chk1(int_n, 1'b1, "int after reads");
    end
    $display("test status done");

    host.write_reg(ADDR_MASK1, 8'hFF);
    host.write_reg(ADDR_MASK2, 8'h13);
    pulse(8'hFF, 8'h13);
    cyc(6);
    chk1(int_n, 1'b1, "all masked");
    rd_chk(ADDR_STAT1, STAT1_VALID);
    rd_chk(ADDR_STAT2, STAT2_VALID);
    host.write_reg(ADDR_MASK1, 8'h00);
    host.write_reg(ADDR_MASK2, 8'h00);
    $display("test mask done");

    @(posedge clk);
    f1 <= 8'h01;
    cyc(3);
    rd_chk(ADDR_STAT1, 8'h01);
    rd_chk(ADDR_STAT1, 8'h01);
    chk1(int_n, 1'b0, "fresh indication");
    @(posedge clk);
    f1 <= 8'h00;
    rd_chk(ADDR_STAT1, 8'h01);
    rd_chk(ADDR_STAT1, 8'h00);
    $display("test persist done");

    host.write_reg(ADDR_CFG, 8'h01);
    pulse(8'h08, 8'h00);
    cyc(4);
    chk1(int_n, 1'b1, "int disabled");
    host.write_reg(ADDR_CFG, 8'h03);
    cyc(2);
    chk1(int_n, 1'b0, "int enabled");
    host.write_reg(ADDR_CFG, 8'h02);
    cyc(2);
    chk1(int_n, 1'b0, "standby keeps int");
    chk1(scan, 1'b0, "standby");
    host.write_reg(ADDR_CFG, 8'h0B);
    cyc(2);
    chk1(int_n, 1'b1, "int clear");
    chk1(scan, 1'b0, "suspended");
    pulse(8'h01, 8'h00);
    cyc(3);
    rd_chk(ADDR_STAT1, 8'h08);
    host.write_reg(ADDR_CFG, 8'h03);
    cyc(1);
    chk1(scan, 1'b1, "resumed");
    $display("test control done");

    host.write_reg(ADDR_CFG, 8'h13);
    cyc(3);
    chk1(rst_n, 1'b1, "reset not enabled");
    rd_chk(ADDR_CFG, 8'h03);
    host.write_reg(ADDR_MASK2, 8'h80);
    host.write_reg(ADDR_CFG, 8'h13);
    count_low(1'b0, n);
    chk8(n[7:0], PC[7:0], "reset length");
    host.write_reg(ADDR_CFG, 8'h13);
    rd_chk(ADDR_CFG, 8'h03);
    chk1(rst_n, 1'b0, "reset active");
    count_low(1'b0, n);
    $display("test reset pulse done");

    for (int k = 0; k < 2; k++)
    begin
      host.write_reg(k ? ADDR_CI_CLEAR : ADDR_CFG, k ? 8'h80 : 8'h43);
      count_low(1'b1, n);
      chk8(n[7:0], PC[7:0], "chassis length");
      rd_chk(k ? ADDR_CI_CLEAR : ADDR_CFG, k ? 8'h00 : 8'h03);
    end
    rd_chk(ADDR_STAT2, 8'h00);
    $display("test chassis done");

    host.write_reg(8'h50, 8'hFF);
    host.write_reg(ADDR_FAN_DIV, 8'hF0);
    host.write_reg(ADDR_TEMP_CFG, 8'h02);
    host.write_reg(ADDR_MASK1, 8'hA5);
    host.write_reg(ADDR_MASK2, 8'h13);
    pulse(8'h02, 8'h00);
    cyc(2);
    chk8({4'h0, fdiv}, 8'h0F, "fan divisor");
    chk8({6'h00, tmode}, 8'h02, "temp mode");
    host.write_reg(ADDR_CFG, 8'h80);
    cyc(2);
    chk8({4'h0, fdiv}, {4'h0, FAN_DIV_RST}, "fan default");
    chk8({6'h00, tmode}, TEMP_CFG_RST, "temp default");
    chk1(int_n, 1'b1, "int after init");
    ta = '{ADDR_CFG, ADDR_MASK1, ADDR_MASK2, ADDR_STAT1, ADDR_FAN_DIV, 8'h50};
    te = '{CFG_RST, 8'h00, 8'h00, 8'h00, {FAN_DIV_RST, 4'hA}, 8'h00};
    for (int k = 0; k < 6; k++)
      rd_chk(ta[k], te[k]);
    rd_chk(ADDR_ADDR45(), 8'h00);
    $display("test init done");
    print_verdict();
  end

  function automatic logic [7:0] ADDR_ADDR45();
    return 8'h45;
  endfunction
endmodule
